//--- src/dbsp_async_rx.sv
/*
 * Asynchronous receiver for modes 1 to 3: start bit check at mid bit,
 * eight data bits lsb first, optional ninth bit, stop bit.
 * Assumes a synchronised line and a 16x tick pulse on the same clock.
 */
`timescale 1ns/1ps
`include "dbsp_defines.svh"

module dbsp_async_rx
   import dbsp_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       rxTick,
   input  wire logic       rxEnable,
   input  wire logic       nineBit,
   input  wire logic       rxLine,
   // result
   output logic            charDone,
   output dbsp_char_t      charOut
);

   dbsp_rx_state_t state_r;
   logic [3:0]     tickCnt_r;
   logic [3:0]     bitIdx_r;
   logic           lineLast_r;
   logic [3:0]     lastIdx;

   assign lastIdx = nineBit ? `DBSP_LAST_M23 : `DBSP_LAST_M1;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lineLast_r <= 1'b1;
      end else begin
         lineLast_r <= rxLine;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= DBSP_RX_IDLE;
         tickCnt_r <= 4'h0;
         bitIdx_r  <= 4'h0;
         charDone  <= 1'b0;
         charOut   <= '0;
      end else begin
         charDone <= 1'b0;
         unique case (state_r)
            DBSP_RX_IDLE: begin
               // falling edge only while enabled
               if (rxEnable && lineLast_r && !rxLine) begin
                  state_r   <= DBSP_RX_START;
                  tickCnt_r <= 4'h0;
                  bitIdx_r  <= 4'h0;
               end
            end
            DBSP_RX_START: begin
               if (rxTick) begin
                  tickCnt_r <= tickCnt_r + 4'h1;
                  if (tickCnt_r == `DBSP_TICK_MID) begin
                     // glitch, not a start bit
                     if (rxLine) begin
                        state_r <= DBSP_RX_IDLE;
                     end else begin
                        state_r <= DBSP_RX_SHIFT;
                     end
                  end
               end
            end
            DBSP_RX_SHIFT: begin
               if (rxTick) begin
                  tickCnt_r <= tickCnt_r + 4'h1;
                  if (tickCnt_r == `DBSP_TICK_MID) begin
                     bitIdx_r <= bitIdx_r + 4'h1;
                     if (bitIdx_r < 4'h8) begin
                        charOut.data <= {rxLine, charOut.data[7:1]};
                     end else if (nineBit && bitIdx_r == 4'h8) begin
                        charOut.ninth <= rxLine;
                     end
                     if (bitIdx_r + 4'h1 == lastIdx) begin
                        charOut.stop <= rxLine;
                        charDone     <= 1'b1;
                        state_r      <= DBSP_RX_IDLE;
                     end
                  end
               end
            end
            default: state_r <= DBSP_RX_IDLE;
         endcase
      end
   end

endmodule

//--- src/dbsp_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the double buffered serial port.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef DBSP_DEFINES_SVH
`define DBSP_DEFINES_SVH

// register byte offsets on the wishbone slave
`define DBSP_OFS_DATA      4'h0
`define DBSP_OFS_CTRL      4'h4
`define DBSP_OFS_STAT      4'h8
`define DBSP_OFS_BAUD      4'hc

// control register fields
`define DBSP_CTRL_MODE_HI  7
`define DBSP_CTRL_MODE_LO  6
`define DBSP_CTRL_RXEN     4
`define DBSP_CTRL_TXNINE   3
`define DBSP_CTRL_RXNINE   2
`define DBSP_CTRL_TXDONE   1
`define DBSP_CTRL_RXDONE   0
`define DBSP_CTRL_RESET    8'h00

// status register fields
`define DBSP_STAT_OVERRUN  0
`define DBSP_STAT_BREAK    1
`define DBSP_STAT_TXBUSY   2
`define DBSP_STAT_HOLDFULL 3

// baud source select fields
`define DBSP_BAUD_RXT2     0
`define DBSP_BAUD_TXT2     1

// timing: ticks per bit, sample point, mode 2 divider
`define DBSP_TICKS_LAST    4'hf
`define DBSP_TICK_MID      4'h7
`define DBSP_M0_RISE       4'h8
`define DBSP_M2_DIV_LAST   1'h1

// last bit index of a frame per mode
`define DBSP_LAST_M0       4'h7
`define DBSP_LAST_M1       4'h9
`define DBSP_LAST_M23      4'ha

// break: full character time in rx ticks
`define DBSP_BRK_TICKS_8   8'ha0
`define DBSP_BRK_TICKS_9   8'hb0

`endif

//--- src/dbsp_pkg.sv
/*
 * Types shared by the serial port modules.
 * Assumes dbsp_defines.svh is on the include path.
 */
`include "dbsp_defines.svh"

package dbsp_pkg;

   typedef enum logic [1:0] {
      DBSP_MODE_SHIFT = 2'b00,
      DBSP_MODE_UART8 = 2'b01,
      DBSP_MODE_FIX9  = 2'b10,
      DBSP_MODE_VAR9  = 2'b11
   } dbsp_mode_t;

   typedef enum logic [1:0] {
      DBSP_RX_IDLE  = 2'b00,
      DBSP_RX_START = 2'b01,
      DBSP_RX_SHIFT = 2'b10
   } dbsp_rx_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic       ninth;
      logic       stop;
   } dbsp_char_t;

endpackage

//--- src/dbsp_serial_port.sv
/*
 * One serial port: four modes, double buffered transmitter, receiver,
 * break detector, overrun flag, separate tx and rx requests, and a
 * classic wishbone register slave.
 * Assumes timer overflow pulses are one clock wide on sys_clk; the
 * serial input pin is asynchronous and synchronised here.
 */
`timescale 1ns/1ps
`include "dbsp_defines.svh"

// Notes on behaviour
// - mode 0: 8 bits lsb first, clock on tx
// - mode 1: start, 8 data, stop, timer baud
// - mode 1 receive stores stop bit
// - mode 2: 11 bits, ninth bit, osc/32
// - send ninth bit from software field
// - modes 2,3 keep ninth bit, ignore stop
// - mode 3 equals mode 2, timer baud
// - timer 1 default, per-port timer 2 select
// - one data address, separate tx/rx registers
// - data write starts transmission, any mode
// - mode 0 receive needs rx done 0, enable
// - async receive starts on start bit, enabled
// - one held byte behind the shifter
// - tx done at stop end or bit 8
// - tx done on write while idle
// - ninth bit read live, not buffered
// - independent break detector, pollable status bit
// - overrun when previous character not taken
// - separate tx and rx requests
// - control holds mode, ninth bits, flags
module dbsp_serial_port
   import dbsp_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // baud sources
   input  wire logic        timer1Ovf,
   input  wire logic        timer2Ovf,
   // pins
   input  wire logic        serialInPin,
   output logic             serialInPinOut,
   output logic             serialInPinOe,
   output logic             serialOutPin,
   // interrupt requests
   output logic             txIrq,
   output logic             rxIrq
);

   ////////////////////////////////////////////////////////////////////
   // registers and shared nets

   dbsp_mode_t  mode_r;
   logic        rxEnable_r;
   logic        txNinth_r;
   logic        rxNinth_r;
   logic        txDone_r;
   logic        rxDone_r;
   logic        overrun_r;
   logic        breakStart_r;
   logic        rxTimerSel_r;
   logic        txTimerSel_r;
   logic [7:0]  rxData_r;
   logic [7:0]  holdData_r;
   logic        holdFull_r;
   logic        busy_r;
   logic        engRx_r;
   logic [7:0]  shiftData_r;
   logic [7:0]  m0RxData_r;
   logic [3:0]  tickCnt_r;
   logic [3:0]  bitIdx_r;
   logic        div2_r;
   logic        pinMeta_r;
   logic        pinSync_r;
   logic [7:0]  breakCnt_r;

   logic        busReq;
   logic        busWr;
   logic        wrData;
   logic        wrCtrl;
   logic        wrStat;
   logic        wrBaud;
   logic        rxTick;
   logic        txTick;
   logic        nineBit;
   logic [3:0]  lastIdx;
   logic        bitEnd;
   logic        frameEnd;
   logic        loadShift;
   logic        m0RxStart;
   logic        m0RxDone;
   logic        txFinish;
   logic        asyncDone;
   dbsp_char_t  asyncChar;
   logic        rxLoad;
   logic [7:0]  breakLimit;
   logic        txLine;

   ////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after request

   assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land on the ack edge, where the master samples ack
   assign busWr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                   && wb_sel_i[0];
   assign wrData = busWr && wb_adr_i == `DBSP_OFS_DATA;
   assign wrCtrl = busWr && wb_adr_i == `DBSP_OFS_CTRL;
   assign wrStat = busWr && wb_adr_i == `DBSP_OFS_STAT;
   assign wrBaud = busWr && wb_adr_i == `DBSP_OFS_BAUD;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= busReq;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (busReq && !wb_we_i) begin
         unique case (wb_adr_i)
            `DBSP_OFS_DATA: wb_dat_o <= {24'h000000, rxData_r};
            `DBSP_OFS_CTRL: wb_dat_o <= {24'h000000, mode_r, 1'b0,
               rxEnable_r, txNinth_r, rxNinth_r, txDone_r,
               rxDone_r};
            `DBSP_OFS_STAT: wb_dat_o <= {28'h0000000, holdFull_r,
               busy_r, breakStart_r, overrun_r};
            `DBSP_OFS_BAUD: wb_dat_o <= {30'h00000000, txTimerSel_r,
               rxTimerSel_r};
            default:        wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control fields written by software

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r     <= DBSP_MODE_SHIFT;
         rxEnable_r <= 1'b0;
         txNinth_r  <= 1'b0;
      end else if (wrCtrl) begin
         mode_r     <= dbsp_mode_t'(wb_dat_i[`DBSP_CTRL_MODE_HI:
                                             `DBSP_CTRL_MODE_LO]);
         rxEnable_r <= wb_dat_i[`DBSP_CTRL_RXEN];
         txNinth_r  <= wb_dat_i[`DBSP_CTRL_TXNINE];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxTimerSel_r <= 1'b0;
         txTimerSel_r <= 1'b0;
      end else if (wrBaud) begin
         rxTimerSel_r <= wb_dat_i[`DBSP_BAUD_RXT2];
         txTimerSel_r <= wb_dat_i[`DBSP_BAUD_TXT2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // baud ticks: 16 per bit in every mode

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div2_r <= 1'b0;
      end else begin
         div2_r <= ~div2_r;
      end
   end

   // modes 1 and 3: timer 1 unless the port selects timer 2; mode 0 ticks every clock, mode 2 every 2nd
   always_comb begin
      unique case (mode_r)
         DBSP_MODE_SHIFT: begin
            rxTick = 1'b1;
            txTick = 1'b1;
         end
         DBSP_MODE_FIX9: begin
            rxTick = div2_r == `DBSP_M2_DIV_LAST;
            txTick = div2_r == `DBSP_M2_DIV_LAST;
         end
         default: begin
            rxTick = rxTimerSel_r ? timer2Ovf : timer1Ovf;
            txTick = txTimerSel_r ? timer2Ovf : timer1Ovf;
         end
      endcase
   end

   assign nineBit = mode_r == DBSP_MODE_FIX9 || mode_r == DBSP_MODE_VAR9;

   always_comb begin
      unique case (mode_r)
         DBSP_MODE_SHIFT: lastIdx = `DBSP_LAST_M0;
         DBSP_MODE_UART8: lastIdx = `DBSP_LAST_M1;
         default:         lastIdx = `DBSP_LAST_M23;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // transmit holding stage and shift engine

   assign bitEnd   = busy_r && txTick && tickCnt_r == `DBSP_TICKS_LAST;
   assign frameEnd = bitEnd && bitIdx_r == lastIdx;
   assign txFinish = frameEnd && !engRx_r;
   assign m0RxDone = frameEnd && engRx_r;
   // next byte loads in the same cycle the frame ends: no gap
   assign loadShift = holdFull_r && (!busy_r || txFinish);
   assign m0RxStart = mode_r == DBSP_MODE_SHIFT && rxEnable_r
                      && !rxDone_r && !busy_r && !holdFull_r
                      && !(wb_cyc_i && wb_stb_i && wb_we_i
                           && wb_adr_i == `DBSP_OFS_DATA);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdData_r <= 8'h00;
         holdFull_r <= 1'b0;
      end else if (wrData) begin
         // a write while full replaces the held byte
         holdData_r <= wb_dat_i[7:0];
         holdFull_r <= 1'b1;
      end else if (loadShift) begin
         holdFull_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r      <= 1'b0;
         engRx_r     <= 1'b0;
         shiftData_r <= 8'h00;
         tickCnt_r   <= 4'h0;
         bitIdx_r    <= 4'h0;
      end else if (loadShift) begin
         busy_r      <= 1'b1;
         engRx_r     <= 1'b0;
         shiftData_r <= holdData_r;
         tickCnt_r   <= 4'h0;
         bitIdx_r    <= 4'h0;
      end else if (m0RxStart) begin
         busy_r    <= 1'b1;
         engRx_r   <= 1'b1;
         tickCnt_r <= 4'h0;
         bitIdx_r  <= 4'h0;
      end else if (frameEnd) begin
         busy_r <= 1'b0;
      end else if (busy_r && txTick) begin
         tickCnt_r <= tickCnt_r + 4'h1;
         if (tickCnt_r == `DBSP_TICKS_LAST) begin
            bitIdx_r <= bitIdx_r + 4'h1;
         end
      end
   end

   // mode 0 samples the data pin on the rising shift clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         m0RxData_r <= 8'h00;
      end else if (busy_r && engRx_r && tickCnt_r == `DBSP_M0_RISE) begin
         m0RxData_r <= {pinSync_r, m0RxData_r[7:1]};
      end
   end

   // frame bit value; ninth bit taken live from the field
   always_comb begin
      if (bitIdx_r == 4'h0) begin
         txLine = 1'b0;
      end else if (bitIdx_r < 4'h9) begin
         txLine = shiftData_r[3'(bitIdx_r - 4'h1)];
      end else if (bitIdx_r == 4'h9 && nineBit) begin
         txLine = txNinth_r;
      end else begin
         txLine = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins, all registered

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         serialOutPin   <= 1'b1;
         serialInPinOut <= 1'b1;
         serialInPinOe  <= 1'b0;
      end else if (mode_r == DBSP_MODE_SHIFT) begin
         // shift clock low for the first half of each bit
         serialOutPin   <= !(busy_r && tickCnt_r < `DBSP_M0_RISE);
         serialInPinOut <= shiftData_r[bitIdx_r[2:0]];
         serialInPinOe  <= busy_r && !engRx_r;
      end else begin
         serialOutPin   <= busy_r && !engRx_r ? txLine : 1'b1;
         serialInPinOut <= 1'b1;
         serialInPinOe  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receive path

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_r <= 1'b1;
         pinSync_r <= 1'b1;
      end else begin
         pinMeta_r <= serialInPin;
         pinSync_r <= pinMeta_r;
      end
   end

   dbsp_async_rx u_async_rx (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .rxTick   (rxTick),
      .rxEnable (rxEnable_r && mode_r != DBSP_MODE_SHIFT),
      .nineBit  (nineBit),
      .rxLine   (pinSync_r),
      .charDone (asyncDone),
      .charOut  (asyncChar)
   );

   assign rxLoad = asyncDone || m0RxDone;

   // an unread character is kept and the new one dropped
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxData_r  <= 8'h00;
         rxNinth_r <= 1'b0;
      end else if (rxLoad && !rxDone_r) begin
         rxData_r <= asyncDone ? asyncChar.data : m0RxData_r;
         if (mode_r == DBSP_MODE_UART8) begin
            rxNinth_r <= asyncChar.stop;
         end else if (nineBit) begin
            rxNinth_r <= asyncChar.ninth;
         end
      end else if (wrCtrl) begin
         rxNinth_r <= wb_dat_i[`DBSP_CTRL_RXNINE];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags: hardware set wins over a software clear

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txDone_r <= 1'b0;
      end else if (txFinish || (wrData && !busy_r && !holdFull_r)) begin
         txDone_r <= 1'b1;
      end else if (wrCtrl) begin
         txDone_r <= wb_dat_i[`DBSP_CTRL_TXDONE];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxDone_r <= 1'b0;
      end else if (rxLoad) begin
         rxDone_r <= 1'b1;
      end else if (wrCtrl) begin
         rxDone_r <= wb_dat_i[`DBSP_CTRL_RXDONE];
      end
   end

   // status flags clear by writing one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_r <= 1'b0;
      end else if (rxLoad && rxDone_r) begin
         overrun_r <= 1'b1;
      end else if (wrStat && wb_dat_i[`DBSP_STAT_OVERRUN]) begin
         overrun_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // break detector, runs beside the receiver

   assign breakLimit = nineBit ? `DBSP_BRK_TICKS_9 : `DBSP_BRK_TICKS_8;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         breakCnt_r <= 8'h00;
      end else if (pinSync_r || mode_r == DBSP_MODE_SHIFT) begin
         breakCnt_r <= 8'h00;
      end else if (rxTick && breakCnt_r != breakLimit) begin
         breakCnt_r <= breakCnt_r + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         breakStart_r <= 1'b0;
      end else if (rxTick && breakCnt_r + 8'h01 == breakLimit
                   && !pinSync_r && mode_r != DBSP_MODE_SHIFT) begin
         breakStart_r <= 1'b1;
      end else if (wrStat && wb_dat_i[`DBSP_STAT_BREAK]) begin
         breakStart_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // two separate requests toward the interrupt controller

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txIrq <= 1'b0;
         rxIrq <= 1'b0;
      end else begin
         txIrq <= txDone_r;
         rxIrq <= rxDone_r;
      end
   end

endmodule

//--- test/dbsp_remote_model.sv
/* remote asynchronous serial device.
   assumes bit time given in sys_clk cycles by the caller. */
`timescale 1ns/1ps
module dbsp_remote_model (
   // clock
   input wire logic sys_clk,
   // line from the port
   input wire logic txLine,
   // line to the port
   output logic     rxLine
);
   // idle line is pulled high
   initial rxLine = 1'b1;
   // start low, nb bits lsb first, then back to idle
   task automatic send(input int nb, input logic [9:0] v, input int bc);
      @(posedge sys_clk) rxLine <= 1'b0;
      repeat (bc - 1) @(posedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         @(posedge sys_clk) rxLine <= v[i];
         repeat (bc - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk) rxLine <= 1'b1;
   endtask
   // samples mid bit, returns at middle of the last bit
   task automatic recv(input int nb, input int bc, output logic [9:0] v);
      v = 10'h0;
      @(negedge txLine);
      repeat (bc / 2) @(posedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (bc) @(posedge sys_clk);
         v[i] = txLine;
      end
   endtask
endmodule

//--- test/dbsp_serial_port_asserts.sv
/* port-level checker for the serial port.
   assumes bind to dbsp_serial_port, one clock domain. */
`timescale 1ns/1ps
module dbsp_sp_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pins
   input wire logic        serialOutPin,
   input wire logic        serialInPinOe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_follows: assert property (req |=> wb_ack_o)
      else $error("request not acked");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
      else $error("ack without request");
   a_unmapped_zero: assert property
      (req && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
      else $error("odd address read not zero");
   a_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_dat_hold: assert property
      (!(req && !wb_we_i) |=> $stable(wb_dat_o))
      else $error("read data moved");
   a_shift_clock: assert property
      ($fell(serialOutPin) && serialInPinOe |->
       (!serialOutPin)[*8] ##1 serialOutPin[*8])
      else $error("shift clock shape wrong");
   a_oe_hold: assert property
      ($rose(serialInPinOe) |-> serialInPinOe[*8])
      else $error("drive enable too short");
   cover property ($rose(serialInPinOe));
   cover property (req && wb_we_i);
   cover property ($fell(serialOutPin) && !serialInPinOe);
endmodule
bind dbsp_serial_port dbsp_sp_chk chk_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .serialOutPin(serialOutPin), .serialInPinOe(serialInPinOe));

//--- test/dbsp_serial_port_tb.sv
/* self-checking bench for the serial port.
   assumes timer 1 pulses every 2nd clock, timer 2 every 4th. */
`timescale 1ns/1ps
`include "dbsp_defines.svh"
module dbsp_serial_port_tb
   import dbsp_pkg::*;
;
   localparam logic [3:0] DA = `DBSP_OFS_DATA;
   localparam logic [3:0] CT = `DBSP_OFS_CTRL;
   localparam logic [3:0] ST = `DBSP_OFS_STAT;
   localparam logic [3:0] BD = `DBSP_OFS_BAUD;
   logic        sys_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, t1 = 1'b0, t2 = 1'b0, ack, pinOut, pinOe;
   logic        outPin, txIrq, rxIrq, rxPin;
   logic [3:0]  adr = 4'h0;
   logic [1:0]  tCnt = 2'h0;
   logic [31:0] wDat = 32'h0, rDat, dOut;
   logic [9:0]  v1, v2;
   logic [7:0]  m0v = 8'h00;
   int          miscompares = 0, n_compared = 0, cycN = 0;
   // shared pin level: port drives it only in mode 0 transmit
   wire         lineIn = pinOe ? pinOut : rxPin;
   always #50 sys_clk = ~sys_clk;
   dbsp_serial_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wDat), .wb_dat_o(dOut), .wb_ack_o(ack),
      .timer1Ovf(t1), .timer2Ovf(t2), .serialInPin(lineIn),
      .serialInPinOut(pinOut), .serialInPinOe(pinOe),
      .serialOutPin(outPin), .txIrq(txIrq), .rxIrq(rxIrq));
   dbsp_remote_model rm_u (.sys_clk(sys_clk), .txLine(outPin),
      .rxLine(rxPin));
   ////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("compared %0d wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // timer pulses and the hang limit
   always @(posedge sys_clk) begin
      tCnt <= tCnt + 2'h1;
      t1 <= tCnt[0];
      t2 <= &tCnt;
      cycN <= cycN + 1;
      if (cycN == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic wbx(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wDat <= {24'h0, d};
      do @(posedge sys_clk); while (ack !== 1'b1 && ++k < 50);
      // a silent slave counts as a mismatch
      if (k >= 50) miscompares++;
      rDat = dOut;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wbx(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wbx(1'b0, a, 8'h00);
      cmp(rDat, {24'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(CT, 8'h00);
      rd(ST, 8'h00);
      rd(4'h2, 8'h00);
      wr(BD, 8'h00);
      wr(CT, 8'h50);
      fork
         begin
            rm_u.recv(9, 32, v1);
            rm_u.recv(9, 32, v2);
         end
         begin
            wr(DA, 8'ha5);
            rd(CT, 8'h52);
            wr(CT, 8'h50);
            wr(DA, 8'h3c);
         end
      join
      cmp({22'h0, v1}, 32'h1a5);
      cmp({22'h0, v2}, 32'h13c);
      repeat (20) @(posedge sys_clk);
      rd(CT, 8'h52);
      cmp({31'h0, txIrq}, 32'h1);
      rm_u.send(9, 10'h196, 32);
      rd(CT, 8'h57);
      rd(DA, 8'h96);
      rm_u.send(9, 10'h10f, 32);
      rd(ST, 8'h01);
      rd(DA, 8'h96);
      wr(ST, 8'h01);
      wr(CT, 8'h50);
      rm_u.send(10, 10'h000, 32);
      rd(ST, 8'h02);
      wr(ST, 8'h02);
      wr(BD, 8'h03);
      wr(CT, 8'hd0);
      fork
         rm_u.recv(10, 64, v1);
         begin
            wr(DA, 8'h5a);
            wr(CT, 8'hd0);
            wr(CT, 8'hd8);
         end
      join
      cmp({22'h0, v1}, 32'h35a);
      rm_u.send(10, 10'h2c3, 64);
      rd(CT, 8'hdb);
      wr(BD, 8'h00);
      wr(CT, 8'h90);
      rm_u.send(10, 10'h13c, 32);
      rd(CT, 8'h95);
      wr(CT, 8'h00);
      // collect the data pin on each rising shift clock, lsb first
      fork
         repeat (8) begin
            @(posedge outPin);
            m0v = {pinOut, m0v[7:1]};
         end
         begin
            wr(DA, 8'h83);
            wr(CT, 8'h00);
         end
      join
      cmp({24'h0, m0v}, 32'h83);
      repeat (150) @(posedge sys_clk);
      rd(CT, 8'h02);
      wr(CT, 8'h10);
      repeat (150) @(posedge sys_clk);
      rd(DA, 8'hff);
      rd(CT, 8'h11);
      cmp({31'h0, rxIrq}, 32'h1);
      end_sim();
   end
endmodule
